/* rtl/ivml_core.sv */
/*
  Interrupt vector selection and maskable interrupt gating with an Avalon-MM
  register slave. Assumes same-clock one-cycle source pulses, a CPU core that
  flags instruction boundaries, and a vector memory answering in the cycle its read strobe stands.
*/
// Added by the designer: the Avalon-MM slave port and the register addresses.
module ivml_core (
  input wire logic mclk_i, // Clock, 200 MHz.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic [7:0] avs_address_i, // Register byte address.
  input wire logic avs_read_i, // Register read request.
  input wire logic avs_write_i, // Register write request.
  input wire logic [31:0] avs_writedata_i, // Register write data.
  input wire logic [3:0] avs_byteenable_i, // Write byte lanes.
  output logic [31:0] avs_readdata_o, // Register read data.
  output logic avs_waitrequest_o, // Slave stall.
  input wire logic [13:0] src_req_i, // Peripheral request pulses.
  input wire ivml_pkg::ivml_trap_s trap_i, // Non-maskable event from core.
  output logic trap_ready_o, // Trap slot free.
  input wire logic cpu_boundary_i, // Core may take a maskable request.
  output logic mem_rd_o, // Vector byte read strobe.
  output logic [19:0] mem_addr_o, // Vector byte address.
  input wire logic [7:0] mem_rdata_i, // Vector byte, sampled at the edge that ends the strobe.
  output logic vec_valid_o, // Handler address ready pulse.
  output ivml_pkg::ivml_vec_s vec_o // Handler address and cause.
);
  import ivml_pkg::*;

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  // Fixed vector slot of a trap kind.
  function automatic logic [19:0] fixed_vec(input ivml_trap_e k);
    logic [19:0] a;
    a = VEC_RESET;
    case (k)
      TK_ILLEGAL: a = VEC_ILLEGAL;
      TK_OVERFLOW: a = VEC_OVERFLOW;
      TK_BREAK: a = VEC_BREAK;
      TK_ADDR_MATCH: a = VEC_ADDR_MATCH;
      TK_SINGLE_STEP: a = VEC_SINGLE_STEP;
      TK_WATCHDOG: a = VEC_WATCHDOG;
      TK_DEBUG: a = VEC_DEBUG;
      default: a = VEC_RESET;
    endcase
    return a;
  endfunction

  // Variable table entry address for a software interrupt number.
  function automatic logic [19:0] var_vec(input logic [19:0] base, input logic [5:0] n);
    return base + {12'h000, n, 2'b00};
  endfunction

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  ivml_state_e st;
  logic iflag;
  logic [2:0] cpu_priority_threshold;
  logic [19:0] vec_base;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0][2:0] lvl;
  logic trap_pend;
  ivml_trap_e trap_kind;
  logic [5:0] trap_num;
  logic [19:0] fetch_addr;
  logic [1:0] byte_cnt;
  logic [31:0] vec_word;
  logic cur_var;
  logic cur_maskable;
  ivml_trap_e cur_kind;
  logic [5:0] cur_num;
  logic [2:0] cur_lvl;
  logic [19:0] last_vec;

  // ------------------------------------------------------------------
  // Register bus decode
  // ------------------------------------------------------------------
  logic acc;
  logic wr_commit;
  logic ctrl_hit;
  logic [3:0] ctrl_idx;
  logic [7:0] ctrl_ofs;
  logic [31:0] next_rdata;

  // A request is committed on the edge where waitrequest stands low.
  assign acc = avs_read_i | avs_write_i;
  assign wr_commit = avs_write_i & ~avs_waitrequest_o;
  assign ctrl_ofs = avs_address_i - OFS_CTRL_BASE;
  assign ctrl_idx = ctrl_ofs[5:2];
  assign ctrl_hit = (avs_address_i >= OFS_CTRL_BASE) && (avs_address_i <= OFS_CTRL_LAST) &&
                    (avs_address_i[1:0] == 2'h0);

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    next_rdata = 32'h00000000;
    if (avs_address_i == OFS_FLAG_WORD) begin
      next_rdata[FLD_IFLAG] = iflag;
      next_rdata[FLD_IPL_LSB +: 3] = cpu_priority_threshold;
    end else if (avs_address_i == OFS_VEC_BASE) begin
      next_rdata[19:0] = vec_base;
    end else if (avs_address_i == OFS_STATUS) begin
      next_rdata[NUM_SRC-1:0] = req;
      next_rdata[FLD_BUSY] = (st != ST_IDLE);
    end else if (avs_address_i == OFS_LAST_VEC) begin
      next_rdata[19:0] = last_vec;
    end else if (ctrl_hit) begin
      next_rdata[2:0] = lvl[ctrl_idx];
      next_rdata[FLD_REQ] = req[ctrl_idx];
    end
  end

  // One wait cycle per access, then the answer stands for one edge.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= ~(acc & avs_waitrequest_o);
      if (acc && avs_waitrequest_o) begin
        avs_readdata_o <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Arbitration of maskable requests
  // ------------------------------------------------------------------
  logic cand_ok;
  logic [3:0] cand_idx;
  logic [2:0] cand_lvl;

  // Strict compare keeps the lower index on equal levels.
  always_comb begin
    cand_ok = 1'b0;
    cand_idx = 4'h0;
    cand_lvl = 3'h0;
    for (int k = 0; k < NUM_SRC; k++) begin
      if (req[k] && (lvl[k] > cpu_priority_threshold) && (!cand_ok || lvl[k] > cand_lvl)) begin
        cand_ok = 1'b1;
        cand_idx = 4'(k);
        cand_lvl = lvl[k];
      end
    end
    cand_ok = cand_ok & iflag;
  end

  logic start_trap;
  logic start_mask;
  logic take_trap;
  logic brk_redirect;

  assign start_trap = (st == ST_IDLE) && trap_pend;
  assign start_mask = (st == ST_IDLE) && !trap_pend && cpu_boundary_i && cand_ok;
  // Overflow trap only counts when the core reports overflow set.
  assign take_trap = trap_i.valid && trap_ready_o &&
                     !(trap_i.kind == TK_OVERFLOW && !trap_i.ovf_flag);
  assign brk_redirect = (cur_kind == TK_BREAK) && !cur_var && (vec_word == VEC_ERASED);

  // ------------------------------------------------------------------
  // Flag word and vector base
  // ------------------------------------------------------------------
  // Software owns the mask flag; acceptance loads the threshold.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iflag <= RST_IFLAG;
      cpu_priority_threshold <= RST_IPL;
    end else begin
      if (wr_commit && avs_address_i == OFS_FLAG_WORD && avs_byteenable_i[0]) begin
        iflag <= avs_writedata_i[FLD_IFLAG];
        cpu_priority_threshold <= avs_writedata_i[FLD_IPL_LSB +: 3];
      end
      if (start_mask) begin
        cpu_priority_threshold <= cand_lvl;
      end
    end
  end

  // Base of the relocatable table.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_base <= RST_VEC_BASE;
    end else if (wr_commit && avs_address_i == OFS_VEC_BASE) begin
      vec_base <= 20'(be_merge({12'h000, vec_base}, avs_writedata_i, avs_byteenable_i));
    end
  end

  // ------------------------------------------------------------------
  // Per-source control registers
  // ------------------------------------------------------------------
  generate
    for (genvar k = 0; k < NUM_SRC; k++) begin : g_src
      logic sw_wr;
      assign sw_wr = wr_commit && ctrl_hit && (ctrl_idx == 4'(k)) && avs_byteenable_i[0];

      // Hardware set wins over any clear in the same cycle.
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          req[k] <= 1'b0;
        end else if (src_req_i[k]) begin
          req[k] <= 1'b1;
        end else if (start_mask && cand_idx == 4'(k)) begin
          req[k] <= 1'b0;
        end else if (sw_wr && !avs_writedata_i[FLD_REQ]) begin
          req[k] <= 1'b0;
        end
      end

      // Level field, zero disables the source.
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          lvl[k] <= 3'h0;
        end else if (sw_wr) begin
          lvl[k] <= avs_writedata_i[2:0];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Non-maskable event slot
  // ------------------------------------------------------------------
  logic next_trap_pend;

  assign next_trap_pend = take_trap | (trap_pend & ~start_trap);

  // The slot starts full with a reset event so the reset vector is fetched first.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_pend <= 1'b1;
      trap_kind <= TK_RESET;
      trap_num <= 6'h00;
      trap_ready_o <= 1'b0;
    end else begin
      trap_pend <= next_trap_pend;
      trap_ready_o <= ~next_trap_pend;
      if (take_trap) begin
        trap_kind <= trap_i.kind;
        trap_num <= trap_i.num;
      end
    end
  end

  // ------------------------------------------------------------------
  // Vector fetch sequencer
  // ------------------------------------------------------------------
  // Picks the slot, reads four bytes low first, then reports the handler.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= ST_IDLE;
      fetch_addr <= 20'h00000;
      byte_cnt <= 2'h0;
      vec_word <= 32'h00000000;
      cur_var <= 1'b0;
      cur_maskable <= 1'b0;
      cur_kind <= TK_RESET;
      cur_num <= 6'h00;
      cur_lvl <= 3'h0;
    end else begin
      case (st)
        ST_IDLE: begin
          byte_cnt <= 2'h0;
          if (start_trap) begin
            st <= ST_REQ;
            cur_kind <= trap_kind;
            cur_num <= trap_num;
            cur_lvl <= 3'h0;
            cur_maskable <= 1'b0;
            cur_var <= (trap_kind == TK_SOFT);
            fetch_addr <= (trap_kind == TK_SOFT) ? var_vec(vec_base, trap_num)
                                                 : fixed_vec(trap_kind);
          end else if (start_mask) begin
            st <= ST_REQ;
            cur_kind <= TK_SOFT;
            cur_num <= SRC_NUM[cand_idx];
            cur_lvl <= cand_lvl;
            cur_maskable <= 1'b1;
            cur_var <= 1'b1;
            fetch_addr <= var_vec(vec_base, SRC_NUM[cand_idx]);
          end
        end
        ST_REQ: begin
          st <= ST_CAP;
        end
        ST_CAP: begin
          vec_word[8*byte_cnt +: 8] <= mem_rdata_i;
          byte_cnt <= byte_cnt + 2'h1;
          st <= (byte_cnt == VEC_LAST_BYTE) ? ST_DONE : ST_REQ;
        end
        ST_DONE: begin
          if (brk_redirect) begin
            st <= ST_REQ;
            cur_var <= 1'b1;
            cur_num <= 6'h00;
            fetch_addr <= var_vec(vec_base, 6'h00);
          end else begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Byte reads go out one per request state.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rd_o <= 1'b0;
      mem_addr_o <= 20'h00000;
    end else begin
      mem_rd_o <= (st == ST_REQ);
      if (st == ST_REQ) begin
        mem_addr_o <= fetch_addr + {18'h00000, byte_cnt};
      end
    end
  end

  // Handler address is presented for one cycle after the last byte.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_valid_o <= 1'b0;
      vec_o <= '0;
      last_vec <= 20'h00000;
    end else begin
      vec_valid_o <= (st == ST_DONE) && !brk_redirect;
      if (st == ST_DONE && !brk_redirect) begin
        vec_o <= '{addr: vec_word[19:0], num: cur_num, level: cur_lvl, maskable: cur_maskable};
        last_vec <= vec_word[19:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_mask_needs_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start_mask |-> iflag && req[cand_idx] && (lvl[cand_idx] > cpu_priority_threshold))
    else $error("maskable request accepted without flag, request or level");

  a_threshold_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start_mask |=> (cpu_priority_threshold == $past(cand_lvl)))
    else $error("threshold not loaded with accepted level");

  a_request_cleared: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start_mask |=> (req[$past(cand_idx)] == $past(src_req_i[cand_idx])))
    else $error("accepted request bit not cleared");

  a_request_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (src_req_i != 14'h0000) |=> ((req & $past(src_req_i)) == $past(src_req_i)))
    else $error("source pulse did not set its request bit");

  a_sw_never_sets: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (src_req_i == 14'h0000) |=> ((req & ~$past(req)) == 14'h0000))
    else $error("request bit rose without a source pulse");

  a_fixed_region: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mem_rd_o && !cur_var) |-> (mem_addr_o >= VEC_FIXED_LOW))
    else $error("fixed vector read outside the fixed area");

  a_table_window: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mem_rd_o && cur_var) |-> ((mem_addr_o - vec_base) < {11'h000, VAR_TABLE_BYTES}))
    else $error("variable vector read outside the table");

  a_fetch_bounded: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st == ST_IDLE && (start_trap || start_mask)) |-> ##[9:19] vec_valid_o)
    else $error("vector not delivered in time");

  a_flag_gates_all: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !iflag |-> !start_mask)
    else $error("maskable request taken with mask flag clear");

  a_break_redirect: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st == ST_DONE && brk_redirect) |=> (st == ST_REQ) && (fetch_addr == vec_base))
    else $error("erased break vector not redirected to entry zero");

endmodule // ivml_core

/* rtl/ivml_pkg.sv */
/*
  Package of the interrupt vector and mask logic: register offsets, field
  positions, reset values, vector addresses, source numbers and carrier types.
  Assumes a 20-bit CPU address space and a byte-wide vector fetch port.
*/
// Functional notes
// - Fixed vectors live between FFFDC and FFFFF and are fetched from their slot.
// - Each vector is four bytes, the handler address, read low byte first.
// - Illegal opcode at FFFDC, overflow trap (overflow set) at FFFE0, break at FFFE4.
// - Address match FFFE8, step FFFEC, watchdog FFFF0, debugger FFFF4, reset FFFFC.
// - A break vector of all ones redirects to variable table entry zero.
// - The variable table is 256 bytes starting at the writable vector base register.
// - Entry n sits at base plus 4n to 4n+3, numbers 0 to 63.
// - Key input uses 13, converter 14, serial transmit and receive 17 to 20.
// - Timer A0 21, timers X 22 to 24, B0 26, B1 27.
// - External requests 0 and 1 use numbers 29 and 30.
// - Software numbers 0 and 32 to 63 ignore the global mask flag.
// - Maskable requests need flag, level and threshold; others bypass all three.
// - Each source has request bit and level; flag and threshold sit in flag word.
// - Mask flag one enables, zero disables all maskable requests; zero after reset.
// - A source request sets its request bit regardless of mask and level.
// - Accepting a request clears its request bit.
// - Accept only with flag set, request set and level above threshold.
// - Level is three bits; zero disables, seven is highest.
// - On acceptance the threshold takes the accepted level.
package ivml_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_FLAG_WORD = 8'h00;
  localparam logic [7:0] OFS_VEC_BASE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_LAST_VEC = 8'h0C;
  localparam logic [7:0] OFS_CTRL_BASE = 8'h40;
  localparam logic [7:0] OFS_CTRL_LAST = 8'h74;

  localparam int FLD_IFLAG = 0;
  localparam int FLD_IPL_LSB = 4;
  localparam int FLD_REQ = 3;
  localparam int FLD_BUSY = 16;

  localparam logic RST_IFLAG = 1'h0;
  localparam logic [2:0] RST_IPL = 3'h0;
  localparam logic [19:0] RST_VEC_BASE = 20'h00000;

  // ------------------------------------------------------------------
  // Vector addresses and table shape
  // ------------------------------------------------------------------
  localparam logic [19:0] VEC_ILLEGAL = 20'hFFFDC;
  localparam logic [19:0] VEC_OVERFLOW = 20'hFFFE0;
  localparam logic [19:0] VEC_BREAK = 20'hFFFE4;
  localparam logic [19:0] VEC_ADDR_MATCH = 20'hFFFE8;
  localparam logic [19:0] VEC_SINGLE_STEP = 20'hFFFEC;
  localparam logic [19:0] VEC_WATCHDOG = 20'hFFFF0;
  localparam logic [19:0] VEC_DEBUG = 20'hFFFF4;
  localparam logic [19:0] VEC_RESET = 20'hFFFFC;
  localparam logic [19:0] VEC_FIXED_LOW = 20'hFFFDC;
  localparam logic [8:0] VAR_TABLE_BYTES = 9'h100;
  localparam logic [1:0] VEC_LAST_BYTE = 2'h3;
  localparam logic [31:0] VEC_ERASED = 32'hFFFFFFFF;

  // ------------------------------------------------------------------
  // Maskable sources and their software interrupt numbers
  // ------------------------------------------------------------------
  localparam int NUM_SRC = 14;
  localparam logic [5:0] SRC_NUM [0:13] = '{
    6'h0D, 6'h0E, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15,
    6'h16, 6'h17, 6'h18, 6'h1A, 6'h1B, 6'h1D, 6'h1E};

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    TK_ILLEGAL = 4'h0, TK_OVERFLOW = 4'h1, TK_BREAK = 4'h2, TK_ADDR_MATCH = 4'h3,
    TK_SINGLE_STEP = 4'h4, TK_WATCHDOG = 4'h5, TK_DEBUG = 4'h6, TK_RESET = 4'h7,
    TK_SOFT = 4'h8
  } ivml_trap_e;

  typedef struct packed {
    logic valid;
    ivml_trap_e kind;
    logic ovf_flag;
    logic [5:0] num;
  } ivml_trap_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [5:0] num;
    logic [2:0] level;
    logic maskable;
  } ivml_vec_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_REQ = 2'b01, ST_CAP = 2'b10, ST_DONE = 2'b11
  } ivml_state_e;

endpackage

/* testbench/ivml_vec_mem.sv */
/*
  Vector memory model that answers the byte fetches of the interrupt vector logic.
  Assumes the design samples the byte on the edge that closes its read strobe.
*/
module ivml_vec_mem (
  input wire logic mclk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic mem_rd_i, // Byte read strobe.
  input wire logic [19:0] mem_addr_i, // Byte address.
  input wire logic brk_erased_i, // Break vector reads as all ones.
  output logic [7:0] mem_rdata_o // Byte answer.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Answers while the strobe stands; a released bus shows the inverse so stale data never matches.
  always_comb begin
    if (!rst_n_i) begin
      mem_rdata_o = 8'h00;
    end else if (mem_rd_i && brk_erased_i && mem_addr_i[19:2] == 18'h3FFF9) begin
      mem_rdata_o = 8'hFF;
    end else if (mem_rd_i) begin
      mem_rdata_o = mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3C;
    end else begin
      mem_rdata_o = ~(mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3C);
    end
  end
endmodule // ivml_vec_mem

/* testbench/tb_top.sv */
/*
  Self-checking bench of the interrupt vector and mask logic.
  Assumes the vector memory model beside the design and a CPU that is always at a boundary.
*/
`define CHK(a, b) begin if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end cmp_count++; end
module tb_top;
  import ivml_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [13:0] src_req_i = 14'h0000;
  ivml_trap_s trap_i = '0;
  logic trap_ready_o, mem_rd_o, vec_valid_o;
  logic brk_erased = 1'b0;
  logic [19:0] mem_addr_o;
  logic [7:0] mem_rdata_i;
  ivml_vec_s vec_o;
  int fails = 0;
  int cmp_count = 0;
  int vcnt = 0;
  int cyc = 0;
  int n0, lvl;
  logic [19:0] base;
  logic [31:0] rd;
  logic [5:0] n;
  logic [19:0] fixed [8] = '{VEC_ILLEGAL, VEC_OVERFLOW, VEC_BREAK, VEC_ADDR_MATCH,
    VEC_SINGLE_STEP, VEC_WATCHDOG, VEC_DEBUG, VEC_RESET};

  ivml_core DUT (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .src_req_i, .trap_i, .trap_ready_o,
    .cpu_boundary_i(1'b1), .mem_rd_o, .mem_addr_o, .mem_rdata_i, .vec_valid_o, .vec_o);
  ivml_vec_mem u_mem (.mclk_i, .rst_n_i, .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
    .brk_erased_i(brk_erased), .mem_rdata_o(mem_rdata_i));

  // ----------------------------------------------------------------
  // Clock, vector counter and hang guard
  // ----------------------------------------------------------------
  // Toggles the 200 MHz clock.
  always #2.5 mclk_i = ~mclk_i;
  // Counts handler pulses and cuts a hung run short.
  always @(posedge mclk_i) begin
    if (vec_valid_o === 1'b1) vcnt++;
    cyc++;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Expectations and drivers
  // ----------------------------------------------------------------
  // Byte the memory model holds at an address.
  function automatic logic [7:0] mb(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  // Handler address built low byte first from the first three bytes, 20 bits.
  function automatic logic [19:0] hv(input logic [19:0] a);
    logic [7:0] b2;
    b2 = mb(a + 20'h00002);
    return {b2[3:0], mb(a + 20'h00001), mb(a)};
  endfunction
  // One Avalon access held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge mclk_i);
    avs_address_i <= adr;
    avs_writedata_i <= wd;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // Offers one trap event until the slot is seen free.
  task automatic trap(input ivml_trap_e k, input logic ovf, input logic [5:0] num);
    @(posedge mclk_i);
    trap_i <= '{1'b1, k, ovf, num};
    do @(posedge mclk_i); while (trap_ready_o !== 1'b1);
    trap_i.valid <= 1'b0;
  endtask
  // One-cycle pulse on the chosen sources.
  task automatic src(input logic [13:0] m);
    @(posedge mclk_i);
    src_req_i <= m;
    @(posedge mclk_i);
    src_req_i <= 14'h0000;
  endtask
  // Waits for the next handler pulse and checks address and class.
  task automatic chk_vec(input int c0, input logic [19:0] a, input logic m);
    do @(negedge mclk_i); while (vcnt == c0);
    `CHK(vec_o.addr, hv(a))
    `CHK(vec_o.maskable, m)
  endtask
  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Runs the scenarios in order.
  initial begin
    rd = $urandom(53863);
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    chk_vec(0, VEC_RESET, 1'b0);
    bus(1'b0, OFS_FLAG_WORD, 32'h0);
    `CHK(rd[6:0], 7'h00)
    base = 20'($urandom);
    bus(1'b1, OFS_VEC_BASE, {12'h000, base});
    bus(1'b0, OFS_VEC_BASE, 32'h0);
    `CHK(rd[19:0], base)
    for (int i = 0; i < 8; i++) begin
      n0 = vcnt;
      trap(ivml_trap_e'(i), 1'b1, 6'h00);
      chk_vec(n0, fixed[i], 1'b0);
    end
    n0 = vcnt;
    trap(TK_OVERFLOW, 1'b0, 6'h00);
    repeat (30) @(negedge mclk_i);
    `CHK(vcnt, n0)
    @(posedge mclk_i);
    brk_erased <= 1'b1;
    trap(TK_BREAK, 1'b1, 6'h00);
    chk_vec(n0, base, 1'b0);
    @(posedge mclk_i);
    brk_erased <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'h20 + 6'($urandom_range(31));
      n0 = vcnt;
      trap(TK_SOFT, 1'b0, n);
      chk_vec(n0, base + 20'(n) * 20'h4, 1'b0);
      `CHK(vec_o.num, n)
    end
    for (int k = 0; k < NUM_SRC; k++) begin
      lvl = $urandom_range(7, 1);
      bus(1'b1, OFS_FLAG_WORD, 32'h0);
      bus(1'b1, OFS_CTRL_BASE + 8'(4 * k), 32'(lvl));
      n0 = vcnt;
      src(14'(1) << k);
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[k], 1'b1)
      `CHK(vcnt, n0)
      bus(1'b1, OFS_FLAG_WORD, 32'h1);
      chk_vec(n0, base + 20'(SRC_NUM[k]) * 20'h4, 1'b1);
      `CHK(vec_o.num, SRC_NUM[k])
      `CHK(vec_o.level, 3'(lvl))
      bus(1'b0, OFS_FLAG_WORD, 32'h0);
      `CHK(rd[6:0], {3'(lvl), 4'h1})
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[k], 1'b0)
    end
    bus(1'b1, OFS_FLAG_WORD, 32'h0);
    bus(1'b1, OFS_CTRL_BASE, 32'h0);
    bus(1'b1, OFS_CTRL_BASE + 8'h08, 32'h3);
    bus(1'b1, OFS_CTRL_BASE + 8'h24, 32'h5);
    bus(1'b1, OFS_CTRL_BASE + 8'h30, 32'h5);
    src(14'h1205);
    n0 = vcnt;
    bus(1'b1, OFS_FLAG_WORD, 32'h1);
    chk_vec(n0, base + 20'(SRC_NUM[9]) * 20'h4, 1'b1);
    `CHK(vec_o.num, SRC_NUM[9])
    repeat (20) @(negedge mclk_i);
    `CHK(vcnt, n0 + 1)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[13:0], 14'h1005)
    bus(1'b1, OFS_CTRL_BASE + 8'h30, 32'h5);
    bus(1'b1, OFS_CTRL_BASE + 8'h24, 32'hD);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[13:0], 14'h0005)
    n0 = vcnt;
    bus(1'b1, OFS_FLAG_WORD, 32'h1);
    chk_vec(n0, base + 20'(SRC_NUM[2]) * 20'h4, 1'b1);
    `CHK(vec_o.num, SRC_NUM[2])
    wrap_up();
  end
endmodule // tb_top
